// >>> hw/ccu_pkg.sv
// Constants for the capture/compare timer unit
// Behaviour
// [R1] Counter advances once per prescaled four-clock instruction cycle, wraps after 65536.
// [R2] Prescaler offers divide-by-one and divide-by-eight, stretching overflow interval.
// [R3] Low four bits of control register select rising or falling edge capture.
// [R4] Each selected capture edge sets flag; interrupt raised when enable bit set.
// [R5] Software captures rising, then falling for width, then rising for period.
// [R6] Mode 1011 raises interrupt and clears counter when counter equals match.
// [R7] Mode 1011 match also sets converter go bit when converter enabled.
// [R8] Mode 1010 match only raises interrupt; counter keeps running.
// [R9] Match value held as low and high byte registers, compared as sixteen bits.
// [R10] Capture latches full sixteen-bit count into low and high capture bytes.
package ccu_pkg;
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PRESCALE = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_MATCH_LOW = 8'h0C;
  localparam logic [7:0] OFF_MATCH_HIGH = 8'h10;
  localparam logic [7:0] OFF_CAPTURE_LOW = 8'h14;
  localparam logic [7:0] OFF_CAPTURE_HIGH = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  localparam logic [7:0] OFF_CONVERTER = 8'h24;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAPTURE_FALL = 4'h4;
  localparam logic [3:0] MODE_CAPTURE_RISE = 4'h5;
  localparam logic [3:0] MODE_MATCH_ONLY = 4'hA;
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
  localparam int STAT_CAPTURE = 0;
  localparam int STAT_MATCH = 1;
  localparam int STAT_OVERFLOW = 2;
  localparam int STAT_WIDTH = 3;
  localparam int CONV_ENABLE = 0;
  localparam int CONV_GO = 1;
  localparam logic [1:0] INSTR_DIV = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/edge_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser with rise/fall detection
module edge_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pinIn,
  output logic rise,
  output logic fall
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;
  logic agree;

  // A change counts only once the second and third stages agree
  always_comb begin
    stage_next = {stage_reg[1:0], pinIn};
    agree = stage_reg[1] == stage_reg[2];
    level_next = agree ? stage_reg[2] : level_reg;
  end

  // Low reset level matches the idle pin, so no false edge after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  // First stage feeds only the second
  assign rise = agree & stage_reg[2] & ~level_reg;
  assign fall = agree & ~stage_reg[2] & level_reg;
endmodule

// >>> hw/capture_compare_timer_unit.sv
`timescale 1ns/1ps
// Capture/compare unit with prescaled counter and AXI4-Lite registers
module capture_compare_timer_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic captureIn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic conversionStart
);
  import ccu_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic edgeRise;
  logic edgeFall;

  edge_sync captureSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(captureIn),
    .rise(edgeRise),
    .fall(edgeFall)
  );

  ////////////////////////////////////////////////////////////////
  logic [3:0] mode_reg, mode_next;
  logic unitEnable_reg, unitEnable_next;
  logic prescale8_reg, prescale8_next;
  logic counterRun_reg, counterRun_next;
  logic [1:0] instr_reg, instr_next;
  logic [2:0] pre_reg, pre_next;
  logic [15:0] count_reg, count_next;
  logic [7:0] matchLow_reg, matchLow_next;
  logic [7:0] matchHigh_reg, matchHigh_next;
  logic [15:0] capture_reg, capture_next;
  logic [3:0] status_reg, status_next;
  logic [3:0] mask_reg, mask_next;
  logic convEnable_reg, convEnable_next;
  logic convGo_reg, convGo_next;
  logic irq_reg, irq_next;
  logic convStart_reg, convStart_next;

  logic awHeld_reg, awHeld_next;
  logic wHeld_reg, wHeld_next;
  logic [7:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic arReady_reg, arReady_next;
  logic rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;
  logic awReady_reg, awReady_next;
  logic wReady_reg, wReady_next;

  logic tick;
  logic wrap;
  logic matchHit;
  logic captureHit;
  logic doWrite;
  logic [3:0] statusSet;
  logic [3:0] w1c;

  function automatic logic known_offset(input logic [7:0] a);
    case (a)
      OFF_CONTROL, OFF_PRESCALE, OFF_COUNT, OFF_MATCH_LOW, OFF_MATCH_HIGH,
      OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH, OFF_STATUS, OFF_MASK, OFF_CONVERTER:
        known_offset = 1'b1;
      default:
        known_offset = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    merge_byte = s[0] ? d[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Timer and capture/compare engine
  always_comb begin
    instr_next = instr_reg;
    pre_next = pre_reg;
    count_next = count_reg;
    capture_next = capture_reg;
    tick = 1'b0;
    if (counterRun_reg) begin
      instr_next = instr_reg + 2'h1; // see [R1]
      if (instr_reg == INSTR_DIV) begin
        pre_next = pre_reg + 3'h1; // see [R2]
        tick = prescale8_reg ? (pre_reg == 3'h7) : 1'b1; // see [R2]
        if (!prescale8_reg) begin
          pre_next = 3'h0;
        end
      end
    end
    wrap = tick && count_reg == COUNT_MAX; // see [R1]
    matchHit = unitEnable_reg && count_reg == {matchHigh_reg, matchLow_reg} && tick &&
               (mode_reg == MODE_MATCH_ONLY || mode_reg == MODE_SPECIAL_EVENT); // see [R9]
    captureHit = unitEnable_reg &&
                 ((mode_reg == MODE_CAPTURE_RISE && edgeRise) ||
                  (mode_reg == MODE_CAPTURE_FALL && edgeFall)); // see [R3]
    if (tick) begin
      if (matchHit && mode_reg == MODE_SPECIAL_EVENT) begin
        count_next = 16'h0000; // see [R6]
      end else begin
        count_next = count_reg + 16'h0001; // see [R8]
      end
    end
    if (captureHit) begin
      capture_next = count_reg; // see [R10]
    end
    if (doWrite && awAddr_reg == OFF_COUNT) begin
      count_next = {wStrb_reg[1] ? wData_reg[15:8] : count_reg[15:8],
                    wStrb_reg[0] ? wData_reg[7:0] : count_reg[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time
  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    doWrite = 1'b0;
    if (s_axi_awvalid && !awHeld_reg && !bValid_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg && !bValid_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (awHeld_reg && wHeld_reg) begin
      doWrite = known_offset(awAddr_reg);
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = known_offset(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    awReady_next = !awHeld_next && !bValid_next;
    wReady_next = !wHeld_next && !bValid_next;
  end

  always_comb begin
    arReady_next = 1'b0;
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    if (s_axi_arvalid && !arReady_reg && !rValid_reg) begin
      arReady_next = 1'b1;
      rValid_next = 1'b1;
      rResp_next = known_offset(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_CONTROL: rData_next = {26'h0, unitEnable_reg, 1'b0, mode_reg};
        OFF_PRESCALE: rData_next = {30'h0, counterRun_reg, prescale8_reg};
        OFF_COUNT: rData_next = {16'h0, count_reg};
        OFF_MATCH_LOW: rData_next = {24'h0, matchLow_reg};
        OFF_MATCH_HIGH: rData_next = {24'h0, matchHigh_reg};
        OFF_CAPTURE_LOW: rData_next = {24'h0, capture_reg[7:0]}; // see [R10]
        OFF_CAPTURE_HIGH: rData_next = {24'h0, capture_reg[15:8]}; // see [R10]
        OFF_STATUS: rData_next = {28'h0, status_reg};
        OFF_MASK: rData_next = {28'h0, mask_reg};
        OFF_CONVERTER: rData_next = {30'h0, convGo_reg, convEnable_reg};
        default: rData_next = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control registers, flags and interrupt
  always_comb begin
    mode_next = mode_reg;
    unitEnable_next = unitEnable_reg;
    prescale8_next = prescale8_reg;
    counterRun_next = counterRun_reg;
    matchLow_next = matchLow_reg;
    matchHigh_next = matchHigh_reg;
    mask_next = mask_reg;
    convEnable_next = convEnable_reg;
    convGo_next = convGo_reg;
    w1c = 4'h0;
    if (doWrite && wStrb_reg[0]) begin
      case (awAddr_reg)
        OFF_CONTROL: begin
          mode_next = wData_reg[3:0]; // see [R3]
          unitEnable_next = wData_reg[5]; // see [R4]
        end
        OFF_PRESCALE: begin
          prescale8_next = wData_reg[0];
          counterRun_next = wData_reg[1];
        end
        OFF_MATCH_LOW: matchLow_next = merge_byte(matchLow_reg, wData_reg, wStrb_reg); // see [R9]
        OFF_MATCH_HIGH: matchHigh_next = merge_byte(matchHigh_reg, wData_reg, wStrb_reg); // see [R9]
        OFF_STATUS: w1c = wData_reg[3:0];
        OFF_MASK: mask_next = wData_reg[3:0];
        OFF_CONVERTER: begin
          convEnable_next = wData_reg[CONV_ENABLE];
          convGo_next = wData_reg[CONV_GO];
        end
        default: begin
        end
      endcase
    end
    // Go bit set by special event wins over a same-cycle software write
    if (matchHit && mode_reg == MODE_SPECIAL_EVENT && convEnable_next) begin
      convGo_next = 1'b1; // see [R7]
    end
    convStart_next = matchHit && mode_reg == MODE_SPECIAL_EVENT && convEnable_next; // see [R7]
    statusSet = 4'h0;
    statusSet[STAT_CAPTURE] = captureHit; // see [R4]
    statusSet[STAT_MATCH] = matchHit; // see [R6] [R8]
    statusSet[STAT_OVERFLOW] = wrap;
    statusSet[STAT_WIDTH] = 1'b0;
    // Set wins over write-one-to-clear
    status_next = (status_reg & ~w1c) | statusSet;
    irq_next = |(status_next & mask_next); // see [R4]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= MODE_OFF;
      unitEnable_reg <= 1'b0;
      prescale8_reg <= 1'b0;
      counterRun_reg <= 1'b0;
      instr_reg <= 2'h0;
      pre_reg <= 3'h0;
      count_reg <= 16'h0000;
      matchLow_reg <= 8'h00;
      matchHigh_reg <= 8'h00;
      capture_reg <= 16'h0000;
      status_reg <= 4'h0;
      mask_reg <= 4'h0;
      convEnable_reg <= 1'b0;
      convGo_reg <= 1'b0;
      irq_reg <= 1'b0;
      convStart_reg <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= RESP_OKAY;
      awReady_reg <= 1'b1;
      wReady_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      unitEnable_reg <= unitEnable_next;
      prescale8_reg <= prescale8_next;
      counterRun_reg <= counterRun_next;
      instr_reg <= instr_next;
      pre_reg <= pre_next;
      count_reg <= count_next;
      matchLow_reg <= matchLow_next;
      matchHigh_reg <= matchHigh_next;
      capture_reg <= capture_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      convEnable_reg <= convEnable_next;
      convGo_reg <= convGo_next;
      irq_reg <= irq_next;
      convStart_reg <= convStart_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      arReady_reg <= arReady_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
      awReady_reg <= awReady_next;
      wReady_reg <= wReady_next;
    end
  end

  // Ready is held low while a word is parked, stalling the master
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;

  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign irq = irq_reg;
  assign conversionStart = convStart_reg;
endmodule

// >>> testbench/ccu_monitor.sv
// Port-level assertions for the capture/compare timer unit
`timescale 1ns/1ps
module ccu_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic conversionStart
);
  import ccu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  conv_pulse_a: assert property (conversionStart |=> !conversionStart)
    else $error("conversion start wider than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=>
    !irq && !conversionStart && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  read_pair_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read accept without data");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read answer late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken during response");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  error_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read returned data");
endmodule

// >>> testbench/pulse_source.sv
// Sensor-like pulse source driving the capture input
`timescale 1ns/1ps
module pulse_source (
  input wire logic mclk,
  input wire logic start,
  input wire logic [7:0] width,
  output logic captureIn
);
  initial captureIn = 1'b0;
  // Edges land off the clock, as an unsynchronised sensor would
  always @(posedge mclk) begin
    if (start) begin
      #3 captureIn = 1'b1;
      repeat (width) @(posedge mclk);
      #3 captureIn = 1'b0;
    end
  end
endmodule

// >>> testbench/capture_compare_timer_unit_tb.sv
// Self-checking bench for the capture/compare timer unit
`timescale 1ns/1ps
module capture_compare_timer_unit_tb;
  import ccu_pkg::*;
  logic mclk, rst, start, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, width;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic captureIn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, conversionStart;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [65:0] expQ[$];
  logic [65:0] ent;
  logic [1:0] bQ[$];
  logic [15:0] valA, valB;
  int miscompares, tests_run, cyc, starts, seed, t, d;
  capture_compare_timer_unit i_capture_compare_timer_unit (.mclk, .rst, .captureIn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .conversionStart);
  pulse_source i_pulse_source (.mclk, .start, .width, .captureIn);
  ////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] r = RESP_OKAY);
    logic aw, w, b;
    bQ.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge mclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    // One idle edge keeps back-to-back calls from driving a signal twice
    @(posedge mclk);
  endtask
  // Mask lets the counter be judged where its last ticks are uncertain
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = RESP_OKAY);
    logic got;
    expQ.push_back({m, r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge mclk);
      got = s_axi_rvalid;
      @(posedge mclk);
      if (got) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
    @(posedge mclk);
  endtask
  task automatic waitIrq(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq !== v && n < 1000);
    check("irq", 32'(v), 32'(irq));
    @(posedge mclk);
  endtask
  ////////////////////////////////////////
  always @(negedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ent = expQ.pop_front();
      check("rdata", ent[31:0] & ent[65:34], s_axi_rdata & ent[65:34]);
      check("rresp", 32'(ent[33:32]), 32'(s_axi_rresp));
    end
    if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(bQ.pop_front()), 32'(s_axi_bresp));
    if (conversionStart) starts++;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    seed = 32550;
    rst = 1'b1;
    start = 1'b0;
    width = 8'h3C;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFF_CONTROL, 32'h0);
    rd(OFF_STATUS, 32'h0);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h44, $random(seed), RESP_SLVERR);
    valA = 16'($random(seed));
    valB = 16'($random(seed));
    wr(OFF_MASK, 32'h1);
    wr(OFF_COUNT, 32'(valA));
    wr(OFF_CONTROL, 32'h25);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    waitIrq(1'b1);
    rd(OFF_CAPTURE_LOW, 32'(valA[7:0]));
    rd(OFF_CAPTURE_HIGH, 32'(valA[15:8]));
    wr(OFF_STATUS, 32'h1);
    waitIrq(1'b0);
    wr(OFF_COUNT, 32'(valB));
    wr(OFF_CONTROL, 32'h24);
    waitIrq(1'b1);
    rd(OFF_CAPTURE_LOW, 32'(valB[7:0]));
    rd(OFF_CAPTURE_HIGH, 32'(valB[15:8]));
    wr(OFF_CONVERTER, 32'h1);
    wr(OFF_MASK, 32'h2);
    wr(OFF_MATCH_LOW, 32'h0);
    wr(OFF_MATCH_HIGH, 32'h1);
    for (int i = 0; i < 2; i++) begin
      starts = 0;
      wr(OFF_STATUS, 32'hF);
      wr(OFF_COUNT, 32'hF0);
      wr(OFF_CONTROL, i ? 32'h2B : 32'h2A);
      wr(OFF_PRESCALE, 32'h2);
      waitIrq(1'b1);
      wr(OFF_PRESCALE, 32'h0);
      rd(OFF_COUNT, i ? 32'h0 : 32'h100, 32'hFFF0);
      rd(OFF_CONVERTER, i ? 32'h3 : 32'h1);
      check("starts", 32'(i), 32'(starts));
    end
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_MASK, 32'h4);
    for (int i = 0; i < 2; i++) begin
      d = i ? 8 : 1;
      wr(OFF_STATUS, 32'hF);
      wr(OFF_COUNT, 32'hFFF0);
      wr(OFF_PRESCALE, i ? 32'h3 : 32'h2);
      t = cyc;
      waitIrq(1'b1);
      t = cyc - t;
      check("wrap time", 32'h1, 32'(t > 60 * d - 4 && t < 64 * d + 8));
      wr(OFF_PRESCALE, 32'h0);
      rd(OFF_COUNT, 32'h0, 32'hFFF0);
    end
    wr(OFF_MASK, 32'h0);
    waitIrq(1'b0);
    rd(OFF_STATUS, 32'h4, 32'h4);
    results();
  end
endmodule
bind capture_compare_timer_unit ccu_monitor i_ccu_monitor (.mclk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .irq, .conversionStart);
